// ===== hw/cmid_dispatch.v
// Dispatch unit: classifies events in compatibility mode, pushes state,
// enters the privilege-0 handler and restores state on interrupt return.
// Assumes the core presents events and returns synchronously on CLOCK and
// services the stack write port every cycle (no back-pressure).
//
// Overview of operation
// - Exceptions, NMI and maskable without extension are class 1
// - Maskable interrupts class 2 only with extension
// - Vectored software interrupts are class 3
// - Privilege field bits 12-13 steer class 3
// - Extension enabled by control bit 0
// - 256-bit bitmap routes class 3 per vector
// - Without extension, maskable acts like exception
// - Bad target segment raises protection fault, selector code
// - Dispatch switches to 32-bit privilege 0
// - Push nine state words on privilege-0 stack
// - Clear four data selectors after saving
// - Cleared selectors on return raise no trap
// - Clear compatibility flag, start handler
// - Return reloads flags and selectors from stack
// - Mode flag changes on return only at privilege 0
// - Protection faults delivered on vector 13
// - Virtual flags active with extension, field below 3
//
// Limitations and choices:
// - One event at a time; events and returns offered while BUSY are
//   dropped without notice, so the core must hold them back.
// - The stack port never waits; a core that stalls its stack writes
//   would need a handshake here.
// - The redirection bitmap and the extension bit arrive as ports; the
//   core owns the task state segment and the fourth control register.
// - Class 2 events take the gate path; the virtual interrupt steps
//   beyond the flag gating live in handler software.
// - Task gates are only announced; the switch itself is the core's.
// - Exceptions, NMI and maskable events never take the monitor route.
// - The virtual flag indication is registered, one cycle behind.
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

`include "cmid_defs.vh"

module cmid_dispatch (
    // Clock, reset, enable
    input  wire        CLOCK,
    input  wire        RSTN,
    input  wire        CE,
    // Event request from the core
    input  wire        EVT_VALID,
    input  wire [1:0]  EVT_KIND,
    input  wire [7:0]  EVT_VECTOR,
    // Control inputs
    input  wire        VM_EXT_ENABLE,
    input  wire [255:0] REDIR_BITMAP,
    // Gate descriptor for the vector
    input  wire [1:0]  GATE_TYPE,
    input  wire [15:0] GATE_SELECTOR,
    input  wire        GATE_CONFORMING,
    input  wire [1:0]  GATE_TARGET_DPL,
    // Live architectural state from the core
    input  wire [31:0] CUR_FLAGS,
    input  wire [31:0] CUR_IP,
    input  wire [31:0] CUR_SP,
    input  wire [15:0] CUR_CODE_SEL,
    input  wire [15:0] CUR_STACK_SEL,
    input  wire [63:0] CUR_DATA_SELS,
    input  wire [31:0] PL0_SP,
    // Interrupt return request and stack images
    input  wire        INTERRUPT_RETURN_REQ,
    input  wire [1:0]  CUR_PRIV,
    input  wire [31:0] INTERRUPT_RETURN_FLAGS_IMAGE,
    input  wire [63:0] INTERRUPT_RETURN_DATA_SELS_IMAGE,
    // Stack write port
    output reg         STK_WE,
    output reg  [31:0] STK_ADDR,
    output reg  [31:0] STK_WDATA,
    // Dispatch results
    output reg         BUSY,
    output reg  [1:0]  EVT_CLASS,
    output reg         TO_LEGACY,
    output reg         TASK_SWITCH,
    output reg         HANDLER_START,
    output reg  [7:0]  HANDLER_VECTOR,
    output reg         GP_FAULT,
    output reg  [15:0] GP_ERROR_CODE,
    // Resulting mode state
    output reg  [31:0] FLAGS_OUT,
    output reg  [63:0] DATA_SELS_OUT,
    output reg         PROT32_PL0,
    output reg         VIRT_FLAGS_ACTIVE,
    output reg         INTERRUPT_RETURN_TRAP
);

    // Sequencer states, one-hot
    localparam ST_IDLE  = 3'b001;
    localparam ST_PUSH  = 3'b010;
    localparam ST_ENTER = 3'b100;

    // Sequencer position
    reg  [2:0]  state;
    reg  [3:0]  push_idx;

    // Copies taken at the accept edge; the frame is pushed from
    // these, so the core may move on while the push runs
    reg  [31:0] sv_flags;
    reg  [31:0] sv_ip;
    reg  [31:0] sv_sp;
    reg  [15:0] sv_cs;
    reg  [15:0] sv_ss;
    reg  [63:0] sv_ds;
    reg  [31:0] frame_top;
    reg  [7:0]  sv_vec;

    // Combinational results
    reg  [1:0]  next_class;
    reg  [31:0] push_word;

    // Live mode and field decode
    wire        in_cmode   = CUR_FLAGS[`CMID_FLAG_CMODE_BIT];
    wire        ext_on     = VM_EXT_ENABLE;
    wire [1:0]  io_privilege_field       = CUR_FLAGS[`CMID_FLAG_IO_PRIVILEGE_FIELD_HI:`CMID_FLAG_IO_PRIVILEGE_FIELD_LO];
    wire        redir      = REDIR_BITMAP[EVT_VECTOR];
    wire        soft_int   = (next_class == `CMID_CLASS_3);

    // Routing choices, tested in this order
    // Bitmap bit clear keeps the interrupt in the legacy program
    wire        go_legacy  = soft_int && ext_on && !redir;
    // Without the extension a reduced field sends it to the monitor
    wire        go_monitor = soft_int && !ext_on && (io_privilege_field != `CMID_IO_PRIVILEGE_FIELD_FULL);
    // Gate must point at a nonconforming level-0 segment
    wire        bad_target = GATE_CONFORMING || (GATE_TARGET_DPL != 2'h0);

    // Byte offset of the next slot below the frame top
    wire [31:0] slot_off   = {26'h0, push_idx + 4'h1, 2'b00};

    // Classification of an incoming event
    // Maskable events are class 2 only while the extension is on
    always @* begin
        case (EVT_KIND)
            `CMID_KIND_SOFTINT:  next_class = `CMID_CLASS_3;
            `CMID_KIND_MASKABLE: next_class = ext_on ? `CMID_CLASS_2 : `CMID_CLASS_1;
            default:             next_class = `CMID_CLASS_1;
        endcase
    end

    // Word pushed per slot, from highest address downward
    // Slot 0 holds the fourth data selector; the instruction pointer
    // comes last and sits lowest
    always @* begin
        case (push_idx)
            4'h0:    push_word = {16'h0000, sv_ds[63:48]};
            4'h1:    push_word = {16'h0000, sv_ds[47:32]};
            4'h2:    push_word = {16'h0000, sv_ds[31:16]};
            4'h3:    push_word = {16'h0000, sv_ds[15:0]};
            4'h4:    push_word = {16'h0000, sv_ss};
            4'h5:    push_word = sv_sp;
            4'h6:    push_word = sv_flags;
            4'h7:    push_word = {16'h0000, sv_cs};
            default: push_word = sv_ip;
        endcase
    end

    // Main sequencer: accepts an event, pushes the frame, enters the
    // handler, and serves returns while idle. CE low freezes every
    // register, including the one-cycle answers.
    always @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            // Sequencer
            state <= ST_IDLE;
            push_idx <= 4'h0;

            // Captured frame
            sv_flags <= 32'h00000000;
            sv_ip <= 32'h00000000;
            sv_sp <= 32'h00000000;
            sv_cs <= 16'h0000;
            sv_ss <= 16'h0000;
            sv_ds <= 64'h0000000000000000;
            frame_top <= `CMID_RESET_SP;
            sv_vec <= 8'h00;

            // Stack port
            STK_WE <= 1'b0;
            STK_ADDR <= 32'h00000000;
            STK_WDATA <= 32'h00000000;

            // Answers and mode state
            BUSY <= 1'b0;
            EVT_CLASS <= 2'h0;
            TO_LEGACY <= 1'b0;
            TASK_SWITCH <= 1'b0;
            HANDLER_START <= 1'b0;
            HANDLER_VECTOR <= 8'h00;
            GP_FAULT <= 1'b0;
            GP_ERROR_CODE <= 16'h0000;
            FLAGS_OUT <= 32'h00000000;
            DATA_SELS_OUT <= 64'h0000000000000000;
            PROT32_PL0 <= 1'b0;
            INTERRUPT_RETURN_TRAP <= 1'b0;
        end else if (CE) begin
            // Pulses last one cycle
            STK_WE <= 1'b0;
            TO_LEGACY <= 1'b0;
            TASK_SWITCH <= 1'b0;
            HANDLER_START <= 1'b0;
            GP_FAULT <= 1'b0;
            // Zero selectors are legal on return, so this never rises
            INTERRUPT_RETURN_TRAP <= 1'b0;
            case (state)
                ST_IDLE: begin
                    // Events outside compatibility mode belong to other logic
                    if (EVT_VALID && in_cmode) begin
                        // Class is recorded even when no gate is used
                        EVT_CLASS <= next_class;
                        sv_vec <= EVT_VECTOR;
                        if (go_legacy) begin
                            // Bit clear: stays in the legacy program's table
                            TO_LEGACY <= 1'b1;
                        end else if (go_monitor) begin
                            // Software interrupt below full field goes to the monitor;
                            // no gate is read, so the error code carries no selector
                            GP_FAULT <= 1'b1;
                            GP_ERROR_CODE <= 16'h0000;
                            HANDLER_VECTOR <= `CMID_GP_VECTOR;
                        end else if (GATE_TYPE == `CMID_GATE_TASK) begin
                            // Task gate: announce the switch, push nothing
                            TASK_SWITCH <= 1'b1;
                            HANDLER_VECTOR <= EVT_VECTOR;
                        end else if (bad_target) begin
                            // Broken gate: fault on vector 13 with the gate's selector
                            GP_FAULT <= 1'b1;
                            GP_ERROR_CODE <= GATE_SELECTOR;
                            HANDLER_VECTOR <= `CMID_GP_VECTOR;
                        end else begin
                            // Capture state, then enter 32-bit level 0; the copies
                            // free the core's live registers from this edge on
                            sv_flags <= CUR_FLAGS;
                            sv_ip <= CUR_IP;
                            sv_sp <= CUR_SP;
                            sv_cs <= CUR_CODE_SEL;
                            sv_ss <= CUR_STACK_SEL;
                            sv_ds <= CUR_DATA_SELS;
                            frame_top <= PL0_SP;
                            PROT32_PL0 <= 1'b1;
                            push_idx <= 4'h0;
                            BUSY <= 1'b1;
                            state <= ST_PUSH;
                        end
                    end else if (INTERRUPT_RETURN_REQ) begin
                        // Reload from privilege-0 images; zero selectors are legal
                        DATA_SELS_OUT <= INTERRUPT_RETURN_DATA_SELS_IMAGE;
                        // Only level 0 may move the mode bit; elsewhere the live bit stays
                        if (CUR_PRIV == 2'h0) begin
                            FLAGS_OUT <= INTERRUPT_RETURN_FLAGS_IMAGE;
                            PROT32_PL0 <= ~INTERRUPT_RETURN_FLAGS_IMAGE[`CMID_FLAG_CMODE_BIT];
                        end else begin
                            FLAGS_OUT <= {INTERRUPT_RETURN_FLAGS_IMAGE[31:18], CUR_FLAGS[`CMID_FLAG_CMODE_BIT],
                                          INTERRUPT_RETURN_FLAGS_IMAGE[16:0]};
                        end
                    end else begin
                        // Idle: follow the live flags so the output never goes stale
                        FLAGS_OUT <= CUR_FLAGS;
                    end
                end

                ST_PUSH: begin
                    // One 32-bit slot per cycle, downward from the frame top;
                    // the core adjusts its own stack pointer afterwards
                    STK_WE <= 1'b1;
                    STK_ADDR <= frame_top - slot_off;
                    STK_WDATA <= push_word;
                    // Ninth slot written: the frame is complete
                    if (push_idx == `CMID_PUSH_WORDS - 4'h1) begin
                        state <= ST_ENTER;
                    end else begin
                        push_idx <= push_idx + 4'h1;
                    end
                end

                ST_ENTER: begin
                    // Frame complete: clear selectors and the mode bit, then start
                    DATA_SELS_OUT <= 64'h0000000000000000;
                    FLAGS_OUT <= sv_flags & ~(32'h1 << `CMID_FLAG_CMODE_BIT);
                    HANDLER_START <= 1'b1;
                    HANDLER_VECTOR <= sv_vec;
                    BUSY <= 1'b0;
                    state <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Virtual flags follow the extension and the field in any mode;
    // registered, so they trail a change on the inputs by one cycle
    always @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            VIRT_FLAGS_ACTIVE <= 1'b0;
        end else if (CE) begin
            VIRT_FLAGS_ACTIVE <= ext_on && (io_privilege_field < `CMID_IO_PRIVILEGE_FIELD_FULL);
        end
    end

endmodule // cmid_dispatch
`default_nettype wire

// ===== hw/cmid_defs.vh
// Constants for the compatibility-mode interrupt dispatch unit.
// Included by the dispatch design file; definitions only.
`ifndef CMID_DEFS_VH
`define CMID_DEFS_VH

// Flag register field positions
`define CMID_FLAG_CMODE_BIT     17
`define CMID_FLAG_IO_PRIVILEGE_FIELD_LO       12
`define CMID_FLAG_IO_PRIVILEGE_FIELD_HI       13
`define CMID_FLAG_VINT_BIT      19
`define CMID_FLAG_VPEND_BIT     20
`define CMID_CR4_VMEXT_BIT      0
// Event kinds presented by the core
`define CMID_KIND_EXCEPTION     2'h0
`define CMID_KIND_NMI           2'h1
`define CMID_KIND_MASKABLE      2'h2
`define CMID_KIND_SOFTINT       2'h3
// Dispatch classes
`define CMID_CLASS_1            2'h1
`define CMID_CLASS_2            2'h2
`define CMID_CLASS_3            2'h3
// Gate types
`define CMID_GATE_TRAP32        2'h0
`define CMID_GATE_INT32         2'h1
`define CMID_GATE_TASK          2'h2
// Fixed vectors and levels
`define CMID_GP_VECTOR          8'h0d
`define CMID_IO_PRIVILEGE_FIELD_FULL          2'h3
`define CMID_PUSH_WORDS         4'h9
`define CMID_RESET_SP           32'h00000000

`endif

// ===== dv/cmid_gate_model.sv
// Gate table standing in for handler software's entries for class 1, 2 and 3 events.
// Assumes the bench names the fault kind; lookup is combinational.
`timescale 1ns/1ns
`default_nettype none
module cmid_gate_model (
    // Lookup and fault choice
    input  wire logic [7:0]  vec,
    input  wire logic [1:0]  fault,
    // Gate descriptor
    output logic [1:0]  gtype,
    output logic [15:0] gsel,
    output logic        gconf,
    output logic [1:0]  gdpl
);
    // Legal 32-bit gates unless the bench asks for a task gate or a broken one
    assign gtype = (fault == 2'h1) ? 2'h2 : {1'b0, vec[0]};
    assign gsel  = {vec, 8'h08};
    assign gconf = fault == 2'h2;
    assign gdpl  = (fault == 2'h3) ? 2'h2 : 2'h0;
endmodule // cmid_gate_model
`default_nettype wire

// ===== dv/cmid_dispatch_chk.sv
// Port assertions for the dispatch unit, bound into every instance.
// Assumes events come one at a time while the unit is idle.
`timescale 1ns/1ns
`default_nettype none
module cmid_dispatch_chk (
    // Unit inputs
    input wire logic         CLOCK, RSTN, CE, EVT_VALID, INTERRUPT_RETURN_REQ, VM_EXT_ENABLE,
    input wire logic [1:0]   EVT_KIND, CUR_PRIV,
    input wire logic [7:0]   EVT_VECTOR,
    input wire logic [255:0] REDIR_BITMAP,
    input wire logic [31:0]  CUR_FLAGS, INTERRUPT_RETURN_FLAGS_IMAGE,
    input wire logic [63:0]  INTERRUPT_RETURN_DATA_SELS_IMAGE,
    // Unit outputs
    input wire logic         STK_WE, BUSY, TO_LEGACY, HANDLER_START, GP_FAULT, INTERRUPT_RETURN_TRAP, PROT32_PL0,
    input wire logic         VIRT_FLAGS_ACTIVE,
    input wire logic [1:0]   EVT_CLASS,
    input wire logic [7:0]   HANDLER_VECTOR,
    input wire logic [31:0]  FLAGS_OUT,
    input wire logic [63:0]  DATA_SELS_OUT
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RSTN || !CE);
    // Accepted event and return; BUSY alone marks the unit as occupied
    wire take = !BUSY && EVT_VALID && CUR_FLAGS[17];
    wire interrupt_return = !BUSY && INTERRUPT_RETURN_REQ && !EVT_VALID;

    chk_class_pick: assert property (take |=> EVT_CLASS == (($past(EVT_KIND) == 2'h3) ? 2'h3 :
        ($past(EVT_KIND) == 2'h2 && $past(VM_EXT_ENABLE)) ? 2'h2 : 2'h1)) else $error("class wrong");
    chk_to_legacy: assert property (take && EVT_KIND == 2'h3 && VM_EXT_ENABLE && !REDIR_BITMAP[EVT_VECTOR]
        |=> TO_LEGACY && !BUSY) else $error("no legacy route");
    chk_entry_mode: assert property ($rose(BUSY) |-> PROT32_PL0 && !STK_WE) else $error("no pl0 entry");
    chk_push_words: assert property ($rose(BUSY) |-> ##1 STK_WE [*8] ##1 STK_WE ##1 !STK_WE)
        else $error("push count");
    chk_handler_go: assert property ($rose(BUSY) |-> ##10 HANDLER_START && !BUSY) else $error("late start");
    chk_sels_clear: assert property (HANDLER_START |-> DATA_SELS_OUT == 64'h0 && !FLAGS_OUT[17])
        else $error("not cleared");
    chk_gp_vector: assert property (GP_FAULT |-> HANDLER_VECTOR == 8'h0d) else $error("fault vector");
    chk_interrupt_return_load: assert property (interrupt_return && CUR_PRIV == 2'h0 |=> FLAGS_OUT == $past(INTERRUPT_RETURN_FLAGS_IMAGE)
        && DATA_SELS_OUT == $past(INTERRUPT_RETURN_DATA_SELS_IMAGE) && PROT32_PL0 == !FLAGS_OUT[17]) else $error("reload");
    chk_interrupt_return_keep: assert property (interrupt_return && CUR_PRIV != 2'h0 |=> FLAGS_OUT[17] == $past(CUR_FLAGS[17]))
        else $error("mode changed");
    chk_no_trap: assert property (!INTERRUPT_RETURN_TRAP) else $error("return trap");
    chk_virt_flags: assert property ($past(RSTN) |-> VIRT_FLAGS_ACTIVE ==
        ($past(VM_EXT_ENABLE) && $past(CUR_FLAGS[13:12]) != 2'h3)) else $error("virtual flags");
    // Main outcomes reached
    cov_legacy: cover property (TO_LEGACY);
    cov_fault: cover property (GP_FAULT);
    cov_handler: cover property (HANDLER_START);
endmodule // cmid_dispatch_chk
bind cmid_dispatch cmid_dispatch_chk u_chk (.*);
`default_nettype wire

// ===== dv/tb_cmid_dispatch.sv
// Bench for the dispatch unit: random events, broken gates and returns
// against a queue model. Assumes stack writes never stall; CE held high.
`timescale 1ns/1ns
`default_nettype none
`define CHECK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb_cmid_dispatch;
    // Design inputs
    logic         CLOCK = 0, RSTN = 0, CE = 1, EVT_VALID = 0, VM_EXT_ENABLE = 0, INTERRUPT_RETURN_REQ = 0, GATE_CONFORMING;
    logic [1:0]   EVT_KIND = 0, CUR_PRIV = 0, GATE_TYPE, GATE_TARGET_DPL, fault = 0;
    logic [7:0]   EVT_VECTOR = 0;
    logic [15:0]  GATE_SELECTOR, CUR_CODE_SEL = 0, CUR_STACK_SEL = 0;
    logic [31:0]  CUR_FLAGS = 0, CUR_IP = 0, CUR_SP = 0, PL0_SP = 0, INTERRUPT_RETURN_FLAGS_IMAGE = 0;
    logic [63:0]  CUR_DATA_SELS = 0, INTERRUPT_RETURN_DATA_SELS_IMAGE = 0;
    logic [255:0] REDIR_BITMAP = 0;
    // Design outputs
    wire          STK_WE, BUSY, TO_LEGACY, TASK_SWITCH, HANDLER_START, GP_FAULT, PROT32_PL0, VIRT_FLAGS_ACTIVE;
    wire          INTERRUPT_RETURN_TRAP;
    wire [1:0]    EVT_CLASS;
    wire [7:0]    HANDLER_VECTOR;
    wire [15:0]   GP_ERROR_CODE;
    wire [31:0]   STK_ADDR, STK_WDATA, FLAGS_OUT;
    wire [63:0]   DATA_SELS_OUT;
    // Bench state
    int           error_cnt = 0, n_compared = 0, seed = 6, cycles = 0;
    logic         mode = 0;
    logic [31:0]  word, pushq[$];

    cmid_dispatch dut (.*);
    cmid_gate_model u_gate (.vec(EVT_VECTOR), .fault(fault), .gtype(GATE_TYPE), .gsel(GATE_SELECTOR),
        .gconf(GATE_CONFORMING), .gdpl(GATE_TARGET_DPL));
    always #25 CLOCK = ~CLOCK;

    // Each stack write must be the next modelled word, one slot lower
    always @(posedge CLOCK) if (STK_WE) begin
        `CHECK("stack addr", PL0_SP - 32'd4 * (32'd10 - 32'(pushq.size())), STK_ADDR)
        word = pushq.pop_front();
        `CHECK("stack word", word, STK_WDATA)
    end
    // Hang guard, well above the expected run length
    always @(posedge CLOCK) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            summarize();
        end
    end

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Offer one event and compare its answer with the model's
    task automatic offer(input logic [1:0] kind, input logic ext, input logic cm);
        logic [31:0] fl, ip, sp, top;
        logic [63:0] ds;
        logic [15:0] cs, ss;
        logic [7:0]  v;
        logic [1:0]  f;
        int          want, got;
        {fl, ip, sp, top} = {$random(seed), $random(seed), $random(seed), $random(seed)};
        {ds, cs, ss} = {$random(seed), $random(seed), $random(seed)};
        v = 8'($random(seed));
        f = 2'($random(seed));
        fl[17] = cm;
        want = 3;
        if (!cm) want = 9;
        else if (kind == 2'h3 && ext && !REDIR_BITMAP[v]) want = 0;
        else if (kind == 2'h3 && !ext && fl[13:12] != 2'h3) want = 2;
        else if (f == 2'h1) want = 1;
        else if (f != 2'h0) want = 2;
        pushq = {};
        if (want == 3) pushq = '{{16'h0, ds[63:48]}, {16'h0, ds[47:32]}, {16'h0, ds[31:16]}, {16'h0, ds[15:0]},
            {16'h0, ss}, sp, fl, {16'h0, cs}, ip};
        @(posedge CLOCK);
        {CUR_FLAGS, CUR_IP, CUR_SP, PL0_SP} <= {fl, ip, sp, top};
        {CUR_DATA_SELS, CUR_CODE_SEL, CUR_STACK_SEL} <= {ds, cs, ss};
        {EVT_KIND, VM_EXT_ENABLE, EVT_VECTOR, fault, EVT_VALID} <= {kind, ext, v, f, 1'b1};
        @(posedge CLOCK);
        EVT_VALID <= 1'b0;
        got = 9;
        for (int i = 0; i < 20 && got == 9; i++) begin
            @(negedge CLOCK);
            if (TO_LEGACY) got = 0;
            else if (TASK_SWITCH) got = 1;
            else if (GP_FAULT) got = 2;
            else if (HANDLER_START) got = 3;
        end
        `CHECK("answer", want, got)
        `CHECK("virtual flags", ext && fl[13:12] != 2'h3, VIRT_FLAGS_ACTIVE)
        if (cm) `CHECK("class", (kind == 2'h3) ? 2'h3 : (kind == 2'h2 && ext) ? 2'h2 : 2'h1, EVT_CLASS)
        if (want == 2) `CHECK("fault code", (want == 2 && kind == 2'h3 && !ext && fl[13:12] != 2'h3) ? 16'h0 : {v, 8'h08}, GP_ERROR_CODE)
        if (want == 3) begin
            `CHECK("vector", v, HANDLER_VECTOR)
            `CHECK("flags", fl & 32'hfffdffff, FLAGS_OUT)
            `CHECK("pushes left", 0, pushq.size())
        end
    endtask

    // Interrupt return at a given privilege with a chosen mode bit
    task automatic ret(input logic [1:0] priv, input logic b17);
        logic [31:0] im;
        logic [63:0] ds;
        im = $random(seed);
        im[17] = b17;
        ds = {$random(seed), $random(seed)};
        @(posedge CLOCK);
        {INTERRUPT_RETURN_FLAGS_IMAGE, INTERRUPT_RETURN_DATA_SELS_IMAGE, CUR_PRIV, INTERRUPT_RETURN_REQ} <= {im, ds, priv, 1'b1};
        CUR_FLAGS[17] <= mode;
        if (priv == 2'h0) mode = b17;
        @(posedge CLOCK);
        INTERRUPT_RETURN_REQ <= 1'b0;
        @(negedge CLOCK);
        `CHECK("mode flag", mode, FLAGS_OUT[17])
        `CHECK("selectors", ds, DATA_SELS_OUT)
        `CHECK("prot mode", !mode, PROT32_PL0)
        `CHECK("return trap", 1'b0, INTERRUPT_RETURN_TRAP)
    endtask

    initial begin
        for (int i = 0; i < 8; i++) REDIR_BITMAP[i*32 +: 32] = $random(seed);
        repeat (3) @(posedge CLOCK);
        RSTN <= 1'b1;
        // All kinds, extension on and off, some outside compatibility mode
        for (int n = 0; n < 96; n++) offer(n[1:0], n[2], n[5:3] != 3'h0);
        $display("test dispatch done");
        ret(2'h0, 1'b1);
        ret(2'h3, 1'b0);
        ret(2'h0, 1'b0);
        ret(2'h2, 1'b1);
        $display("test return done");
        summarize();
    end
endmodule // tb_cmid_dispatch
`default_nettype wire
